// [hdl/cte_params.svh]
// Opcodes, cycle counts, flag word layout and reset values of the transfer/exchange unit
`ifndef CTE_PARAMS_SVH
`define CTE_PARAMS_SVH
`define CTE_OPC_TEST_X 16'h2706
`define CTE_OPC_TEST_Y 16'h2716
`define CTE_OPC_TEST_Z 16'h2726
`define CTE_OPC_TEST_EXT 16'h2736
`define CTE_OPC_S2X 16'h274f
`define CTE_OPC_S2Y 16'h275f
`define CTE_OPC_S2Z 16'h276f
`define CTE_OPC_X2S 16'h374e
`define CTE_OPC_Y2S 16'h375e
`define CTE_OPC_Z2S 16'h376e
`define CTE_OPC_X2Y 16'h275c
`define CTE_OPC_X2Z 16'h276c
`define CTE_OPC_Y2X 16'h274d
`define CTE_OPC_Y2Z 16'h276d
`define CTE_OPC_Z2X 16'h274e
`define CTE_OPC_Z2Y 16'h275e
`define CTE_OPC_XKB 16'h37ac
`define CTE_OPC_YKB 16'h37ad
`define CTE_OPC_ZKB 16'h37ae
`define CTE_OPC_SWEX 16'h374c
`define CTE_OPC_SWEY 16'h375c
`define CTE_OPC_SWEZ 16'h376c
`define CTE_OPC_SWAB 16'h371a
`define CTE_OPC_SWDE 16'h277a
`define CTE_OPC_SWDX 16'h37cc
`define CTE_OPC_SWDY 16'h37dc
`define CTE_OPC_SWDZ 16'h37ec
`define CTE_OPC_WAIT 16'h27f3
`define CTE_NIB_IDX_BASE 4'h4
`define CTE_NIB_IDX_ALT 4'hc
`define CTE_CYC_TEST 4'h6
`define CTE_CYC_XFER 4'h2
`define CTE_CYC_WAIT 4'h8
`define CTE_CYC_BAD 4'h2
`define CTE_STACK_ADJ 20'h00002
`define CTE_FLAG_N 11
`define CTE_FLAG_Z 10
`define CTE_FLAG_V 9
`define CTE_FLAG_C 8
`define CTE_RESULT_HI 15
`define CTE_RESULT_LO 4
`define CTE_BANK_HI 3
`define CTE_BANK_LO 0
`define CTE_FLAG_RST 16'h0000
`define CTE_WORD_RST 16'h0000
`define CTE_BANK_RST 4'h0
`endif

// [hdl/cte_pkg.sv]
// Types of the transfer/exchange unit
package cte_pkg;
	typedef enum logic [2:0] {
		CTE_IDLE = 3'b001,
		CTE_EXEC = 3'b010,
		CTE_HALT = 3'b100
	} cte_state_type;
	typedef enum logic [3:0] {
		CTE_OP_NONE = 4'h0,
		CTE_OP_TEST = 4'h1,
		CTE_OP_S2I = 4'h2,
		CTE_OP_I2S = 4'h3,
		CTE_OP_COPY = 4'h4,
		CTE_OP_BANK2B = 4'h5,
		CTE_OP_SWEI = 4'h6,
		CTE_OP_SWDI = 4'h7,
		CTE_OP_SWAB = 4'h8,
		CTE_OP_SWDE = 4'h9,
		CTE_OP_WAIT = 4'ha
	} cte_op_type;
	typedef enum logic [2:0] {
		CTE_REG_A = 3'h0,
		CTE_REG_B = 3'h1,
		CTE_REG_E = 3'h2,
		CTE_REG_X = 3'h3,
		CTE_REG_Y = 3'h4,
		CTE_REG_Z = 3'h5,
		CTE_REG_STACK = 3'h6
	} cte_reg_type;
endpackage : cte_pkg

// [hdl/cte_flag_word.sv]
// Flag word register with result load, stack restore and word test updates
`timescale 1ns/10ps
`include "cte_params.svh"
module cte_flag_word (
	input wire logic clk,
	input wire logic rst,
	input wire logic testValid,
	input wire logic testNeg,
	input wire logic testZero,
	input wire logic resultValid,
	input wire logic [15:0] resultIn,
	input wire logic popAll,
	input wire logic popBank,
	input wire logic [15:0] popIn,
	output logic [15:0] flagWord
);
	import cte_pkg::*;
	logic [15:0] flag_reg;

	always_ff @(posedge clk) begin
		if (rst) begin
			flag_reg <= `CTE_FLAG_RST;
		end else if (popAll) begin
			flag_reg <= popIn; // see RULE8
		end else if (popBank) begin
			flag_reg[`CTE_BANK_HI:`CTE_BANK_LO] <= popIn[`CTE_BANK_HI:`CTE_BANK_LO]; // see RULE9
		end else if (resultValid) begin
			flag_reg[`CTE_RESULT_HI:`CTE_RESULT_LO] <= resultIn[`CTE_RESULT_HI:`CTE_RESULT_LO]; // see RULE7
		end else if (testValid) begin
			flag_reg[`CTE_FLAG_N] <= testNeg; // see RULE1
			flag_reg[`CTE_FLAG_Z] <= testZero;
			flag_reg[`CTE_FLAG_V] <= 1'b0;
			flag_reg[`CTE_FLAG_C] <= 1'b0;
		end
	end

	assign flagWord = flag_reg;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_pop_all_word: assert property (popAll |=> flagWord == $past(popIn)) // see RULE8
		else $error("flag word not replaced by popped value");
	a_pop_bank_only: assert property (popBank && !popAll |=> // see RULE9
		flagWord == {$past(flagWord[15:4]), $past(popIn[3:0])})
		else $error("bank restore touched other flag bits");
	a_result_keeps_bank: assert property (resultValid && !popAll && !popBank |=> // see RULE7
		flagWord == {$past(resultIn[15:4]), $past(flagWord[3:0])})
		else $error("result load wrong or bank field changed");
	a_test_flag_set: assert property (testValid && !resultValid && !popAll && !popBank |=> // see RULE1
		flagWord[11:8] == {$past(testNeg), $past(testZero), 2'b00})
		else $error("word test flags wrong");
endmodule : cte_flag_word

// [hdl/cte_exec.sv]
// Decode and execution of word test, stack/index transfers, copies and exchanges
// Function
// RULE1: Word test sets N,Z, clears V,C; 6 cycles
// RULE2: Stack plus two into index; 2 cycles
// RULE3: Index minus two into stack; 2 cycles
// RULE4: First index copied to second or third
// RULE5: Other index copies move 20 bits unchanged
// RULE6: E swaps with chosen index word; 2 cycles
// RULE7: Result load changes flag bits 15:4 only
// RULE8: Stack restore replaces whole flag word
// RULE9: Bank restore changes program bank field only
// RULE10: Index bank to B low nibble, high cleared
// RULE11: Wait suspends until interrupt; other swaps 2 cycles
`timescale 1ns/10ps
`include "cte_params.svh"
module cte_exec (
	input wire logic clk,
	input wire logic rst,
	input wire logic opValid,
	input wire logic [15:0] opCode,
	output logic opReady,
	output logic opDone,
	output logic opIllegal,
	input wire logic [15:0] memWord,
	input wire logic irqPending,
	output logic haltActive,
	input wire logic regWrEn,
	input wire cte_pkg::cte_reg_type regWrSel,
	input wire logic [19:0] regWrData,
	input wire logic flagResultValid,
	input wire logic [15:0] flagResultIn,
	input wire logic flagPopAll,
	input wire logic flagPopBank,
	input wire logic [15:0] flagPopIn,
	output logic [7:0] accA,
	output logic [7:0] accB,
	output logic [15:0] accE,
	output logic [15:0] firstIndexWord,
	output logic [15:0] secondIndexWord,
	output logic [15:0] thirdIndexWord,
	output logic [3:0] firstIndexBank,
	output logic [3:0] secondIndexBank,
	output logic [3:0] thirdIndexBank,
	output logic [15:0] stackPointer,
	output logic [3:0] stackBankField,
	output logic [15:0] flagWord
);
	import cte_pkg::*;

	function automatic cte_op_type decodeOp(input logic [15:0] code);
		case (code)
			`CTE_OPC_TEST_X, `CTE_OPC_TEST_Y, `CTE_OPC_TEST_Z,
			`CTE_OPC_TEST_EXT: decodeOp = CTE_OP_TEST;
			`CTE_OPC_S2X, `CTE_OPC_S2Y, `CTE_OPC_S2Z: decodeOp = CTE_OP_S2I;
			`CTE_OPC_X2S, `CTE_OPC_Y2S, `CTE_OPC_Z2S: decodeOp = CTE_OP_I2S;
			`CTE_OPC_X2Y, `CTE_OPC_X2Z, `CTE_OPC_Y2X,
			`CTE_OPC_Y2Z, `CTE_OPC_Z2X, `CTE_OPC_Z2Y: decodeOp = CTE_OP_COPY;
			`CTE_OPC_XKB, `CTE_OPC_YKB, `CTE_OPC_ZKB: decodeOp = CTE_OP_BANK2B;
			`CTE_OPC_SWEX, `CTE_OPC_SWEY, `CTE_OPC_SWEZ: decodeOp = CTE_OP_SWEI;
			`CTE_OPC_SWDX, `CTE_OPC_SWDY, `CTE_OPC_SWDZ: decodeOp = CTE_OP_SWDI;
			`CTE_OPC_SWAB: decodeOp = CTE_OP_SWAB;
			`CTE_OPC_SWDE: decodeOp = CTE_OP_SWDE;
			`CTE_OPC_WAIT: decodeOp = CTE_OP_WAIT;
			default: decodeOp = CTE_OP_NONE;
		endcase
	endfunction : decodeOp

	function automatic logic [3:0] cycOf(input cte_op_type o);
		case (o)
			CTE_OP_TEST: cycOf = `CTE_CYC_TEST;
			CTE_OP_WAIT: cycOf = `CTE_CYC_WAIT;
			CTE_OP_NONE: cycOf = `CTE_CYC_BAD;
			default: cycOf = `CTE_CYC_XFER;
		endcase
	endfunction : cycOf

	// Index number from an opcode nibble relative to a base nibble
	function automatic logic [1:0] idxOf(input logic [3:0] nib, input logic [3:0] base);
		logic [3:0] diff;
		diff = nib - base;
		idxOf = diff[1:0];
	endfunction : idxOf

	cte_state_type state_reg;
	logic [3:0] cnt_reg;
	logic waitOp_reg;
	logic [7:0] accA_reg;
	logic [7:0] accB_reg;
	logic [15:0] accE_reg;
	logic [19:0] stack_reg;
	logic [19:0] idxFull [0:2];
	cte_op_type op;
	logic issue;
	logic [1:0] hiIdx;
	logic [1:0] loIdx;
	logic wrFree;

	assign op = decodeOp(opCode);
	assign opReady = (state_reg == CTE_IDLE);
	assign issue = opValid && opReady;
	assign opIllegal = issue && (op == CTE_OP_NONE);
	assign hiIdx = idxOf(opCode[7:4], (op == CTE_OP_SWDI) ? `CTE_NIB_IDX_ALT : `CTE_NIB_IDX_BASE);
	assign loIdx = idxOf(opCode[3:0], `CTE_NIB_IDX_ALT);
	assign wrFree = regWrEn && !issue;
	assign haltActive = (state_reg == CTE_HALT); // see RULE11

	// Sequencer: busy for the instruction's cycle count, then idle or suspended
	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= CTE_IDLE;
		end else begin
			case (state_reg)
				CTE_IDLE: begin
					if (issue) begin
						state_reg <= CTE_EXEC;
					end
				end
				CTE_EXEC: begin
					if (cnt_reg == 4'h1) begin
						state_reg <= (waitOp_reg && !irqPending) ? CTE_HALT : CTE_IDLE; // see RULE11
					end
				end
				CTE_HALT: begin
					if (irqPending) begin
						state_reg <= CTE_IDLE;
					end
				end
				default: state_reg <= CTE_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_reg <= 4'h0;
			waitOp_reg <= 1'b0;
		end else if (issue) begin
			cnt_reg <= cycOf(op) - 4'h1; // see RULE1
			waitOp_reg <= (op == CTE_OP_WAIT);
		end else if (state_reg == CTE_EXEC) begin
			cnt_reg <= cnt_reg - 4'h1;
		end
	end

	assign opDone = ((state_reg == CTE_EXEC) && (cnt_reg == 4'h1) && !(waitOp_reg && !irqPending))
		|| ((state_reg == CTE_HALT) && irqPending);

	// Index registers with their bank fields
	for (genvar gi = 0; gi < 3; gi++) begin : gIdx
		logic [19:0] full_reg;
		logic [19:0] full_next;
		always_comb begin
			full_next = full_reg;
			if (issue) begin
				case (op)
					CTE_OP_S2I: if (hiIdx == 2'(gi)) full_next = stack_reg + `CTE_STACK_ADJ; // see RULE2
					CTE_OP_COPY: if (hiIdx == 2'(gi)) full_next = idxFull[loIdx]; // see RULE4 see RULE5
					CTE_OP_SWEI: if (hiIdx == 2'(gi)) full_next[15:0] = accE_reg; // see RULE6
					CTE_OP_SWDI: if (hiIdx == 2'(gi)) full_next[15:0] = {accA_reg, accB_reg}; // see RULE11
					default: full_next = full_reg;
				endcase
			end else if (wrFree && (regWrSel == cte_reg_type'(3'(gi) + 3'h3))) begin
				full_next = regWrData;
			end
		end
		always_ff @(posedge clk) begin
			if (rst) begin
				full_reg <= {`CTE_BANK_RST, `CTE_WORD_RST};
			end else begin
				full_reg <= full_next;
			end
		end
		assign idxFull[gi] = full_reg;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			stack_reg <= {`CTE_BANK_RST, `CTE_WORD_RST};
		end else if (issue && (op == CTE_OP_I2S)) begin
			stack_reg <= idxFull[hiIdx] - `CTE_STACK_ADJ; // see RULE3
		end else if (wrFree && (regWrSel == CTE_REG_STACK)) begin
			stack_reg <= regWrData;
		end
	end

	// Accumulators A, B and E
	always_ff @(posedge clk) begin
		if (rst) begin
			accA_reg <= 8'(`CTE_WORD_RST >> 8);
			accB_reg <= 8'h00;
			accE_reg <= `CTE_WORD_RST;
		end else if (issue) begin
			case (op)
				CTE_OP_BANK2B: accB_reg <= {4'h0, idxFull[loIdx][19:16]}; // see RULE10
				CTE_OP_SWEI: accE_reg <= idxFull[hiIdx][15:0]; // see RULE6
				CTE_OP_SWDI: {accA_reg, accB_reg} <= idxFull[hiIdx][15:0]; // see RULE11
				CTE_OP_SWAB: begin
					accA_reg <= accB_reg; // see RULE11
					accB_reg <= accA_reg;
				end
				CTE_OP_SWDE: begin
					{accA_reg, accB_reg} <= accE_reg; // see RULE11
					accE_reg <= {accA_reg, accB_reg};
				end
				default: accE_reg <= accE_reg;
			endcase
		end else if (wrFree) begin
			case (regWrSel)
				CTE_REG_A: accA_reg <= regWrData[7:0];
				CTE_REG_B: accB_reg <= regWrData[7:0];
				CTE_REG_E: accE_reg <= regWrData[15:0];
				default: accE_reg <= accE_reg;
			endcase
		end
	end

	cte_flag_word uFlag (
		.clk(clk),
		.rst(rst),
		.testValid(issue && (op == CTE_OP_TEST)), // see RULE1
		.testNeg(memWord[15]),
		.testZero(memWord == 16'h0000),
		.resultValid(flagResultValid), // see RULE7
		.resultIn(flagResultIn),
		.popAll(flagPopAll), // see RULE8
		.popBank(flagPopBank), // see RULE9
		.popIn(flagPopIn),
		.flagWord(flagWord)
	);

	assign accA = accA_reg;
	assign accB = accB_reg;
	assign accE = accE_reg;
	assign {firstIndexBank, firstIndexWord} = idxFull[0];
	assign {secondIndexBank, secondIndexWord} = idxFull[1];
	assign {thirdIndexBank, thirdIndexWord} = idxFull[2];
	assign {stackBankField, stackPointer} = stack_reg;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_test_done_time: assert property (issue && op == CTE_OP_TEST |-> !opDone[*5] ##1 opDone) // see RULE1
		else $error("word test did not finish in 6 cycles");
	a_stack_to_index: assert property (issue && op == CTE_OP_S2I |=> // see RULE2
		idxFull[$past(hiIdx)] == $past(stack_reg) + `CTE_STACK_ADJ ##0 opDone)
		else $error("stack to index transfer wrong");
	a_index_to_stack: assert property (issue && op == CTE_OP_I2S |=> // see RULE3
		stack_reg == $past(idxFull[hiIdx]) - `CTE_STACK_ADJ ##0 opDone)
		else $error("index to stack transfer wrong");
	a_copy_index_pair: assert property (issue && op == CTE_OP_COPY |=> // see RULE5
		idxFull[$past(hiIdx)] == $past(idxFull[loIdx]) ##0 opDone ##1 opReady)
		else $error("index copy wrong or not two cycles");
	a_swap_e_index: assert property (issue && op == CTE_OP_SWEI |=> // see RULE6
		accE == $past(idxFull[hiIdx][15:0]) && idxFull[$past(hiIdx)][15:0] == $past(accE_reg))
		else $error("E and index exchange wrong");
	a_flags_held: assert property (issue && op != CTE_OP_TEST && op != CTE_OP_NONE // see RULE4
		&& !flagResultValid && !flagPopAll && !flagPopBank |=> $stable(flagWord))
		else $error("transfer changed the flag word");
	a_bank_to_b: assert property (issue && op == CTE_OP_BANK2B |=> // see RULE10
		accB == {4'h0, $past(idxFull[loIdx][19:16])})
		else $error("bank field to B wrong");
	a_wait_suspend: assert property (issue && op == CTE_OP_WAIT |=> !opDone[*6]) // see RULE11
		else $error("wait finished before 8 cycles");
	a_halt_release: assert property (haltActive && irqPending |-> opDone ##1 opReady) // see RULE11
		else $error("suspension not released by interrupt");

	c_word_test: cover property (issue && op == CTE_OP_TEST ##5 opDone);
	c_halt_wake: cover property (haltActive ##1 haltActive && irqPending);
	c_copy_then_swap: cover property (issue && op == CTE_OP_COPY ##2 issue && op == CTE_OP_SWEI);
	c_stack_round: cover property (issue && op == CTE_OP_S2I ##2 issue && op == CTE_OP_I2S);
endmodule : cte_exec

// [tb/cpu_transfer_exchange_ops_bench.sv]
// Self-checking bench of the transfer/exchange unit
`timescale 1ns/10ps
module cpu_transfer_exchange_ops_bench;
	import cte_pkg::*;
	typedef struct packed {
		logic [15:0] op;
		logic [15:0] mem;
		logic [3:0] cyc;
		logic ill;
		logic [2:0] s1;
		logic [19:0] v1;
		logic [2:0] s2;
		logic [19:0] v2;
		logic [15:0] fl;
	} cte_row_type;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic opValid = 1'b0;
	logic [15:0] opCode = 16'h0000;
	logic [15:0] memWord = 16'h0000;
	logic irqPending = 1'b0;
	logic regWrEn = 1'b0;
	cte_reg_type regWrSel = CTE_REG_A;
	logic [19:0] regWrData = 20'h00000;
	logic flagResultValid = 1'b0;
	logic [15:0] flagResultIn = 16'h0000;
	logic flagPopAll = 1'b0;
	logic flagPopBank = 1'b0;
	logic [15:0] flagPopIn = 16'h0000;
	logic opReady, opDone, opIllegal, haltActive;
	logic [7:0] accA, accB;
	logic [15:0] accE, firstIndexWord, secondIndexWord, thirdIndexWord, stackPointer, flagWord;
	logic [3:0] firstIndexBank, secondIndexBank, thirdIndexBank, stackBankField;
	int errors = 0;
	int testsRun = 0;
	logic [19:0] ini [7] = '{20'h00012, 20'h00034, 20'h05678, 20'h11111, 20'h22222,
		20'h30001, 20'h9fffe};
	cte_row_type rows [28] = '{
		'{16'h2706, 16'h8000, 4'h6, 1'b0, 3'h2, 20'h05678, 3'h3, 20'h11111, 16'h0805},
		'{16'h2716, 16'h7fff, 4'h6, 1'b0, 3'h2, 20'h05678, 3'h4, 20'h22222, 16'h0005},
		'{16'h2726, 16'h8001, 4'h6, 1'b0, 3'h2, 20'h05678, 3'h5, 20'h30001, 16'h0805},
		'{16'h2736, 16'h0000, 4'h6, 1'b0, 3'h2, 20'h05678, 3'h6, 20'h9fffe, 16'h0405},
		'{16'h274f, 16'h0000, 4'h2, 1'b0, 3'h3, 20'ha0000, 3'h6, 20'h9fffe, 16'h0f05},
		'{16'h275f, 16'h0000, 4'h2, 1'b0, 3'h4, 20'ha0000, 3'h6, 20'h9fffe, 16'h0f05},
		'{16'h276f, 16'h0000, 4'h2, 1'b0, 3'h5, 20'ha0000, 3'h6, 20'h9fffe, 16'h0f05},
		'{16'h374e, 16'h0000, 4'h2, 1'b0, 3'h6, 20'h1110f, 3'h3, 20'h11111, 16'h0f05},
		'{16'h375e, 16'h0000, 4'h2, 1'b0, 3'h6, 20'h22220, 3'h4, 20'h22222, 16'h0f05},
		'{16'h376e, 16'h0000, 4'h2, 1'b0, 3'h6, 20'h2ffff, 3'h5, 20'h30001, 16'h0f05},
		'{16'h275c, 16'h0000, 4'h2, 1'b0, 3'h4, 20'h11111, 3'h3, 20'h11111, 16'h0f05},
		'{16'h276c, 16'h0000, 4'h2, 1'b0, 3'h5, 20'h11111, 3'h3, 20'h11111, 16'h0f05},
		'{16'h274d, 16'h0000, 4'h2, 1'b0, 3'h3, 20'h22222, 3'h4, 20'h22222, 16'h0f05},
		'{16'h276d, 16'h0000, 4'h2, 1'b0, 3'h5, 20'h22222, 3'h4, 20'h22222, 16'h0f05},
		'{16'h274e, 16'h0000, 4'h2, 1'b0, 3'h3, 20'h30001, 3'h5, 20'h30001, 16'h0f05},
		'{16'h275e, 16'h0000, 4'h2, 1'b0, 3'h4, 20'h30001, 3'h5, 20'h30001, 16'h0f05},
		'{16'h37ac, 16'h0000, 4'h2, 1'b0, 3'h1, 20'h00001, 3'h0, 20'h00012, 16'h0f05},
		'{16'h37ad, 16'h0000, 4'h2, 1'b0, 3'h1, 20'h00002, 3'h3, 20'h11111, 16'h0f05},
		'{16'h37ae, 16'h0000, 4'h2, 1'b0, 3'h1, 20'h00003, 3'h5, 20'h30001, 16'h0f05},
		'{16'h374c, 16'h0000, 4'h2, 1'b0, 3'h2, 20'h01111, 3'h3, 20'h15678, 16'h0f05},
		'{16'h375c, 16'h0000, 4'h2, 1'b0, 3'h2, 20'h02222, 3'h4, 20'h25678, 16'h0f05},
		'{16'h376c, 16'h0000, 4'h2, 1'b0, 3'h2, 20'h00001, 3'h5, 20'h35678, 16'h0f05},
		'{16'h371a, 16'h0000, 4'h2, 1'b0, 3'h0, 20'h00034, 3'h1, 20'h00012, 16'h0f05},
		'{16'h277a, 16'h0000, 4'h2, 1'b0, 3'h7, 20'h05678, 3'h2, 20'h01234, 16'h0f05},
		'{16'h37cc, 16'h0000, 4'h2, 1'b0, 3'h7, 20'h01111, 3'h3, 20'h11234, 16'h0f05},
		'{16'h37dc, 16'h0000, 4'h2, 1'b0, 3'h7, 20'h02222, 3'h4, 20'h21234, 16'h0f05},
		'{16'h37ec, 16'h0000, 4'h2, 1'b0, 3'h7, 20'h00001, 3'h5, 20'h31234, 16'h0f05},
		'{16'hffff, 16'h0000, 4'h2, 1'b1, 3'h7, 20'h01234, 3'h6, 20'h9fffe, 16'h0f05}};
	logic [3:0] cyc;
	logic ill;

	cte_exec uut (.clk(clk), .rst(rst), .opValid(opValid), .opCode(opCode), .opReady(opReady),
		.opDone(opDone), .opIllegal(opIllegal), .memWord(memWord), .irqPending(irqPending),
		.haltActive(haltActive), .regWrEn(regWrEn), .regWrSel(regWrSel),
		.regWrData(regWrData), .flagResultValid(flagResultValid),
		.flagResultIn(flagResultIn), .flagPopAll(flagPopAll), .flagPopBank(flagPopBank),
		.flagPopIn(flagPopIn), .accA(accA), .accB(accB), .accE(accE),
		.firstIndexWord(firstIndexWord), .secondIndexWord(secondIndexWord),
		.thirdIndexWord(thirdIndexWord), .firstIndexBank(firstIndexBank),
		.secondIndexBank(secondIndexBank), .thirdIndexBank(thirdIndexBank),
		.stackPointer(stackPointer), .stackBankField(stackBankField), .flagWord(flagWord));

	always #2.5 clk = ~clk;

	function automatic logic [19:0] view(input logic [2:0] s);
		case (s)
			3'h0: view = {12'h000, accA};
			3'h1: view = {12'h000, accB};
			3'h2: view = {4'h0, accE};
			3'h3: view = {firstIndexBank, firstIndexWord};
			3'h4: view = {secondIndexBank, secondIndexWord};
			3'h5: view = {thirdIndexBank, thirdIndexWord};
			3'h6: view = {stackBankField, stackPointer};
			default: view = {4'h0, accA, accB};
		endcase
	endfunction : view

	task automatic report_and_stop();
		if (errors == 0 && testsRun > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : report_and_stop

	task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
		testsRun++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// Offers one instruction, leaves the bench at the middle of the cycle after issue
	task automatic start(input logic [15:0] op, input logic [15:0] mem);
		@(posedge clk);
		opValid <= 1'b1;
		opCode <= op;
		memWord <= mem;
		@(negedge clk);
		check("ready at issue", {19'h0, opReady}, 20'h1);
		ill = opIllegal;
		@(posedge clk);
		opValid <= 1'b0;
		@(negedge clk);
		check("ready while busy", {19'h0, opReady}, 20'h0);
	endtask : start

	task automatic run(input logic [15:0] op, input logic [15:0] mem);
		int n;
		start(op, mem);
		n = 1;
		while (opDone !== 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		if (n >= 20) begin
			errors++;
			report_and_stop();
		end
		cyc = 4'(n + 1);
	endtask : run

	task automatic flags(input logic [2:0] kind, input logic [15:0] v, input logic [15:0] exp);
		@(posedge clk);
		{flagPopAll, flagPopBank, flagResultValid} <= kind;
		flagPopIn <= v;
		flagResultIn <= v;
		@(posedge clk);
		{flagPopAll, flagPopBank, flagResultValid} <= 3'b000;
		@(negedge clk);
		check("flag word", {4'h0, flagWord}, {4'h0, exp});
	endtask : flags

	task automatic setup();
		for (int i = 0; i < 7; i++) begin
			@(posedge clk);
			regWrEn <= 1'b1;
			regWrSel <= cte_reg_type'(i[2:0]);
			regWrData <= ini[i];
		end
		@(posedge clk);
		regWrEn <= 1'b0;
		flags(3'b100, 16'h0f05, 16'h0f05);
	endtask : setup

	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		check("ready after reset", {19'h0, opReady}, 20'h1);
		check("halt after reset", {19'h0, haltActive}, 20'h0);
		check("flags after reset", {4'h0, flagWord}, 20'h0);
		check("stack after reset", view(3'h6), 20'h0);
		foreach (rows[i]) begin
			setup();
			run(rows[i].op, rows[i].mem);
			check("cycles", {16'h0, cyc}, {16'h0, rows[i].cyc});
			check("illegal", {19'h0, ill}, {19'h0, rows[i].ill});
			check("first dest", view(rows[i].s1), rows[i].v1);
			check("second dest", view(rows[i].s2), rows[i].v2);
			check("flags", {4'h0, flagWord}, {4'h0, rows[i].fl});
		end
		setup();
		run(16'h275c, 16'h0000);
		run(16'h276d, 16'h0000);
		check("back to back", view(3'h5), 20'h11111);
		flags(3'b001, 16'hffff, 16'hfff5);
		flags(3'b010, 16'haaac, 16'hfffc);
		flags(3'b101, 16'h1234, 16'h1234);
		@(posedge clk);
		irqPending <= 1'b1;
		run(16'h27f3, 16'h0000);
		check("wait cycles", {16'h0, cyc}, 20'h8);
		@(posedge clk);
		irqPending <= 1'b0;
		start(16'h27f3, 16'h0000);
		repeat (10) @(negedge clk);
		check("halted", {18'h0, haltActive, opDone}, 20'h2);
		@(posedge clk);
		irqPending <= 1'b1;
		@(negedge clk);
		check("wake done", {19'h0, opDone}, 20'h1);
		@(posedge clk);
		irqPending <= 1'b0;
		@(negedge clk);
		check("after wake", {18'h0, haltActive, opReady}, 20'h1);
		setup();
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		check("index after reset", view(3'h3), 20'h0);
		check("flags after reset", {4'h0, flagWord}, 20'h0);
		report_and_stop();
	end
endmodule : cpu_transfer_exchange_ops_bench
